// ==== hdl/micdc_regs.vh ====
`ifndef MICDC_REGS_VH
`define MICDC_REGS_VH

// register byte offsets
`define MICDC_CTRL 8'h00
`define MICDC_CAPS 8'h04
`define MICDC_IDS 8'h08
`define MICDC_MSPCHG 8'h0C
`define MICDC_MSPTIM 8'h10
`define MICDC_STATUS 8'h14
`define MICDC_RXCAPS 8'h18
`define MICDC_RXCHG 8'h1C
`define MICDC_RXTIM 8'h20
`define MICDC_MSPACT 8'h24
`define MICDC_KEYBASE 8'h40
`define MICDC_MABBASE 8'h80

// ctrl fields
`define MICDC_CTRL_SEL 2:0
`define MICDC_CTRL_GO 3
`define MICDC_CTRL_KEYN 10:8
`define MICDC_CTRL_MABN 14:12
`define MICDC_CTRL_MABID 23:16

// element selections
`define MICDC_SEL_CAPS 3'h0
`define MICDC_SEL_KEYS 3'h1
`define MICDC_SEL_CHG 3'h2
`define MICDC_SEL_TIM 3'h3
`define MICDC_SEL_BIND 3'h4

// element lengths and block sizes
`define MICDC_LEN_CAPS 8'h04
`define MICDC_LEN_CHG 8'h03
`define MICDC_LEN_TIM 8'h04
`define MICDC_MIN_CAPS 8'h02
`define MICDC_KEY_SHIFT 4
`define MICDC_BIND_SHIFT 3
`define MICDC_MAX_ENT 3'h4

// capability bitmap: bits 0, 7, 15 reserved
`define MICDC_CAPS_MASK 16'h7F7E
`define MICDC_CAPS_RST 16'h0000
`define MICDC_IDS_RST 32'h00000000

// multicast short address range, upper octet fixed
`define MICDC_MCAST_HI 8'hFF

// timing
`define MICDC_CLK_NS 20
`define MICDC_US_NS 1000
`define MICDC_US_CYC (`MICDC_US_NS / `MICDC_CLK_NS)

`endif

// ==== hdl/micdc_codec.v ====
`include "micdc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module micdc_codec (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // element octet stream to peer
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg tx_last,
    input wire tx_ready,
    // element octet stream from peer
    input wire rx_valid,
    input wire [7:0] rx_data,
    // period boundary from the frame timer
    input wire period_boundary,
    // MAC client binding port
    input wire mcl_bind_valid,
    input wire [1:0] mcl_bind_index,
    input wire [47:0] mcl_ext_ident,
    // group lookup for outgoing frames
    input wire [47:0] grp_ext_ident,
    output reg [15:0] grp_short_addr_q,
    output reg grp_hit_q
);

    reg [31:0] ctrl_q;
    reg [15:0] caps_q;
    reg [31:0] ids_q;
    reg [7:0] chg_cnt_q;
    reg [15:0] chg_int_q;
    reg [15:0] act_int_q;
    reg [15:0] tim_target_q;
    reg [15:0] tim_est_q;
    reg [2:0] rx_flags_q;
    reg [15:0] rx_caps_q;
    reg [23:0] rx_chg_q;
    reg [31:0] rx_tim_q;
    reg [31:0] key_mem [0:15];
    reg [47:0] bind_eui [0:3];
    reg [3:0] bind_vld_q;
    reg [5:0] us_div_q;
    reg [15:0] now_us_q;
    reg busy_q;
    reg [2:0] sel_q;
    reg [7:0] idx_q;
    reg [7:0] len_q;
    reg [15:0] rem_q;
    reg [1:0] rx_st_q;
    reg [7:0] rx_id_q;
    reg [7:0] rx_left_q;
    reg [7:0] rx_pos_q;
    integer i;

    wire wr_en = psel & penable & pwrite;
    wire rd_setup = psel & ~penable;
    wire key_hit = (paddr[7:6] == 2'b01);
    wire bind_hit = (paddr[7:5] == 3'b100);
    reg mapped;
    reg [31:0] rd_d;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // address decode and read mux
    always @* begin
        mapped = 1'b1;
        rd_d = 32'h00000000;
        if (key_hit) begin
            rd_d = key_mem[paddr[5:2]];
        end else if (bind_hit) begin
            if (paddr[2]) begin
                rd_d = {`MICDC_MCAST_HI, 6'h00, paddr[4:3], bind_eui[paddr[4:3]][47:32]};
            end else begin
                rd_d = bind_eui[paddr[4:3]][31:0];
            end
        end else begin
            case (paddr)
                `MICDC_CTRL: rd_d = ctrl_q;
                `MICDC_CAPS: rd_d = {16'h0000, caps_q};
                `MICDC_IDS: rd_d = ids_q;
                `MICDC_MSPCHG: rd_d = {8'h00, chg_int_q, chg_cnt_q};
                `MICDC_MSPTIM: rd_d = {tim_est_q, tim_target_q};
                `MICDC_STATUS: rd_d = {16'h0000, now_us_q[7:0], bind_vld_q, rx_flags_q, busy_q};
                `MICDC_RXCAPS: rd_d = {16'h0000, rx_caps_q};
                `MICDC_RXCHG: rd_d = {8'h00, rx_chg_q};
                `MICDC_RXTIM: rd_d = rx_tim_q;
                `MICDC_MSPACT: rd_d = {16'h0000, act_int_q};
                default: mapped = 1'b0;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rd_d;
        end
    end

    // microsecond time base
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_div_q <= 6'h00;
            now_us_q <= 16'h0000;
        end else if (us_div_q == `MICDC_US_CYC - 1) begin
            us_div_q <= 6'h00;
            now_us_q <= now_us_q + 16'h0001;
        end else begin
            us_div_q <= us_div_q + 6'h01;
        end
    end

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h00000000;
            caps_q <= `MICDC_CAPS_RST;
            ids_q <= `MICDC_IDS_RST;
            chg_int_q <= 16'h0000;
            tim_target_q <= 16'h0000;
            tim_est_q <= 16'h0000;
        end else if (wr_en) begin
            case (paddr)
                `MICDC_CTRL: ctrl_q <= {8'h00, pwdata[23:4], 1'b0, pwdata[2:0]};
                `MICDC_CAPS: caps_q <= pwdata[15:0] & `MICDC_CAPS_MASK;
                `MICDC_IDS: ids_q <= pwdata;
                `MICDC_MSPCHG: chg_int_q <= pwdata[23:8];
                `MICDC_MSPTIM: begin
                    tim_target_q <= pwdata[15:0];
                    tim_est_q <= pwdata[31:16];
                end
                default: ;
            endcase
        end
    end

    always @(posedge pclk) begin
        if (wr_en && key_hit) begin
            key_mem[paddr[5:2]] <= pwdata;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_cnt_q <= 8'h00;
            act_int_q <= 16'h0000;
        end else if (wr_en && paddr == `MICDC_MSPCHG) begin
            chg_cnt_q <= pwdata[7:0];
        end else if (period_boundary) begin
            if (chg_cnt_q == 8'h00) begin
                act_int_q <= chg_int_q;
            end else begin
                chg_cnt_q <= chg_cnt_q - 8'h01;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bind_vld_q <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                bind_eui[i] <= 48'h000000000000;
            end
        end else if (mcl_bind_valid) begin
            bind_eui[mcl_bind_index] <= mcl_ext_ident;
            bind_vld_q[mcl_bind_index] <= 1'b1;
        end
    end

    // lookup of the bound short address
    wire [3:0] grp_match;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lookup
            assign grp_match[g] = bind_vld_q[g] & (bind_eui[g] == grp_ext_ident);
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_short_addr_q <= 16'h0000;
            grp_hit_q <= 1'b0;
        end else begin
            grp_hit_q <= |grp_match;
            grp_short_addr_q <= {`MICDC_MCAST_HI, 6'h00,
                grp_match[3] | grp_match[2], grp_match[3] | grp_match[1]};
        end
    end

    // transmit octet for a given position; multi-octet fields lsb first
    function [7:0] oct;
        input [2:0] sel;
        input [7:0] idx;
        input [7:0] len;
        reg [7:0] b;
        reg [31:0] w;
        begin
            b = idx - 8'h02;
            w = key_mem[b[5:2]];
            oct = 8'h00;
            if (idx == 8'h00) begin
                case (sel)
                    `MICDC_SEL_CAPS: oct = ids_q[7:0];
                    `MICDC_SEL_KEYS: oct = ids_q[15:8];
                    `MICDC_SEL_CHG: oct = ids_q[23:16];
                    `MICDC_SEL_TIM: oct = ids_q[31:24];
                    default: oct = ctrl_q[`MICDC_CTRL_MABID];
                endcase
            end else if (idx == 8'h01) begin
                oct = len;
            end else begin
                case (sel)
                    `MICDC_SEL_CAPS: oct = (b == 8'h00) ? caps_q[7:0] :
                        (b == 8'h01) ? caps_q[15:8] : 8'h00;
                    `MICDC_SEL_KEYS: oct = w[b[1:0]*8 +: 8];
                    `MICDC_SEL_CHG: oct = (b == 8'h00) ? chg_cnt_q :
                        (b == 8'h01) ? chg_int_q[7:0] : chg_int_q[15:8];
                    `MICDC_SEL_TIM: oct = (b == 8'h00) ? rem_q[7:0] :
                        (b == 8'h01) ? rem_q[15:8] :
                        (b == 8'h02) ? tim_est_q[7:0] : tim_est_q[15:8];
                    default: oct = (b[2:0] == 3'h6) ? {6'h00, b[4:3]} :
                        (b[2:0] == 3'h7) ? `MICDC_MCAST_HI :
                        bind_eui[b[4:3]][b[2:0]*8 +: 8];
                endcase
            end
        end
    endfunction

    wire [2:0] go_sel = pwdata[`MICDC_CTRL_SEL];
    // counts ride on the GO word itself; ctrl_q still holds the previous word here
    wire [2:0] key_n = (pwdata[`MICDC_CTRL_KEYN] > `MICDC_MAX_ENT) ?
        `MICDC_MAX_ENT : pwdata[`MICDC_CTRL_KEYN];
    wire [2:0] bind_n = (pwdata[`MICDC_CTRL_MABN] > `MICDC_MAX_ENT) ?
        `MICDC_MAX_ENT : pwdata[`MICDC_CTRL_MABN];
    reg [7:0] go_len;

    always @* begin
        case (go_sel)
            `MICDC_SEL_CAPS: go_len = `MICDC_LEN_CAPS;
            `MICDC_SEL_KEYS: go_len = {1'b0, key_n, 4'h0};
            `MICDC_SEL_CHG: go_len = `MICDC_LEN_CHG;
            `MICDC_SEL_TIM: go_len = `MICDC_LEN_TIM;
            default: go_len = {2'b00, bind_n, 3'h0};
        endcase
    end

    wire go = wr_en && (paddr == `MICDC_CTRL) && pwdata[`MICDC_CTRL_GO] && !busy_q;
    wire tx_adv = tx_valid & tx_ready;

    // element builder
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            sel_q <= 3'h0;
            idx_q <= 8'h00;
            len_q <= 8'h00;
            rem_q <= 16'h0000;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else if (go) begin
            busy_q <= 1'b1;
            sel_q <= go_sel;
            idx_q <= 8'h00;
            len_q <= go_len;
            // time left counted from the moment the element goes out
            rem_q <= tim_target_q - now_us_q;
            tx_valid <= 1'b1;
            // binding id from the GO word, ctrl_q loads on this same edge
            tx_data <= (go_sel > `MICDC_SEL_TIM) ? pwdata[`MICDC_CTRL_MABID] :
                oct(go_sel, 8'h00, go_len);
            tx_last <= 1'b0;
        end else if (tx_adv) begin
            if (tx_last) begin
                busy_q <= 1'b0;
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
            end else begin
                idx_q <= idx_q + 8'h01;
                tx_data <= oct(sel_q, idx_q + 8'h01, len_q);
                tx_last <= (idx_q == len_q);
            end
        end
    end

    // element parser: id, length, then body stepped by the length octet
    localparam RX_ID = 2'h0;
    localparam RX_LEN = 2'h1;
    localparam RX_BODY = 2'h2;
    wire clr_flags = wr_en && (paddr == `MICDC_STATUS);
    reg [2:0] rx_set;

    // flag on the last field octet, reserved tail not needed
    always @* begin
        rx_set = 3'h0;
        if (rx_valid && rx_st_q == RX_BODY) begin
            if (rx_id_q == ids_q[7:0] && rx_pos_q == 8'h01) begin
                rx_set[0] = 1'b1;
            end
            if (rx_id_q == ids_q[23:16] && rx_pos_q == 8'h02) begin
                rx_set[1] = 1'b1;
            end
            if (rx_id_q == ids_q[31:24] && rx_pos_q == 8'h03) begin
                rx_set[2] = 1'b1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q <= RX_ID;
            rx_id_q <= 8'h00;
            rx_left_q <= 8'h00;
            rx_pos_q <= 8'h00;
            rx_caps_q <= 16'h0000;
            rx_chg_q <= 24'h000000;
            rx_tim_q <= 32'h00000000;
            rx_flags_q <= 3'h0;
        end else begin
            if (rx_valid) begin
                case (rx_st_q)
                    RX_ID: begin
                        rx_id_q <= rx_data;
                        rx_st_q <= RX_LEN;
                    end
                    RX_LEN: begin
                        // skip by length regardless of content
                        rx_left_q <= rx_data;
                        rx_pos_q <= 8'h00;
                        rx_st_q <= (rx_data == 8'h00) ? RX_ID : RX_BODY;
                    end
                    RX_BODY: begin
                        if (rx_id_q == ids_q[7:0] && rx_pos_q < `MICDC_MIN_CAPS) begin
                            rx_caps_q[rx_pos_q[0]*8 +: 8] <= rx_data;
                        end
                        if (rx_id_q == ids_q[23:16] && rx_pos_q < `MICDC_LEN_CHG) begin
                            rx_chg_q[rx_pos_q[1:0]*8 +: 8] <= rx_data;
                        end
                        if (rx_id_q == ids_q[31:24] && rx_pos_q < `MICDC_LEN_TIM) begin
                            rx_tim_q[rx_pos_q[1:0]*8 +: 8] <= rx_data;
                        end
                        rx_pos_q <= rx_pos_q + 8'h01;
                        rx_left_q <= rx_left_q - 8'h01;
                        if (rx_left_q == 8'h01) rx_st_q <= RX_ID;
                    end
                    default: rx_st_q <= RX_ID;
                endcase
            end
            // set wins over a write-one clear in the same cycle
            rx_flags_q <= (rx_flags_q & ~(clr_flags ? pwdata[3:1] : 3'h0)) | rx_set;
        end
    end

endmodule

`default_nettype wire

// ==== tb/micdc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module micdc_checker (
    // clock, reset and apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    // octet stream and lookup
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tx_ready,
    input wire [15:0] grp_short_addr_q,
    input wire grp_hit_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire go = acc && pwrite && paddr == 8'h00 && pwdata[3];
    pready_high_a: assert property (pready) else $error("pready low");
    err_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
    err_unmapped_a: assert property (acc && paddr == 8'h28 |-> pslverr)
        else $error("unmapped address not refused");
    err_read_a: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("octet not held");
    tx_start_a: assert property (go && !tx_valid |=> tx_valid) else $error("no start");
    tx_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
        else $error("octet after last");
    last_valid_a: assert property (tx_last |-> tx_valid) else $error("last without valid");
    grp_range_a: assert property (grp_hit_q |-> grp_short_addr_q[15:2] == 14'h3FC0)
        else $error("short address out of range");
    cover property (acc && pslverr);
    cover property (tx_valid && tx_ready && tx_last);
    cover property (grp_hit_q);
endmodule
bind micdc_codec micdc_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .grp_short_addr_q(grp_short_addr_q),
    .grp_hit_q(grp_hit_q));
`default_nettype wire

// ==== tb/micdc_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module micdc_peer (
    // octet sink and source
    input wire pclk,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // random stalls keep the held octet exposed
    always @(posedge pclk) tx_ready <= ($urandom % 3) != 0;
    task send(input [7:0] b);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_data <= b;
    endtask
    // released line shows the inverse, not stale data
    task idle;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule
`default_nettype wire

// ==== tb/mac_info_element_codec_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module mac_info_element_codec_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic period_boundary = 1'b0, mcl_bind_valid = 1'b0;
    logic [1:0] mcl_bind_index = 2'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, v, w;
    logic [47:0] mcl_ext_ident = 48'h0, grp_ext_ident = 48'h0, eui [2];
    wire pready, pslverr, tx_valid, tx_last, tx_ready, rx_valid, grp_hit_q;
    wire [31:0] prdata;
    wire [7:0] tx_data, rx_data;
    wire [15:0] grp_short_addr_q;
    int errors = 0, check_count = 0, cyc = 0, ucyc = 0;
    logic [31:0] exp_rd [$];
    logic [8:0] exp_tx [$];
    logic [7:0] rxq [$];
    always #10 pclk = ~pclk;
    micdc_codec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .period_boundary(period_boundary), .mcl_bind_valid(mcl_bind_valid),
        .mcl_bind_index(mcl_bind_index), .mcl_ext_ident(mcl_ext_ident),
        .grp_ext_ident(grp_ext_ident), .grp_short_addr_q(grp_short_addr_q),
        .grp_hit_q(grp_hit_q));
    micdc_peer peer_u (.pclk(pclk), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data));
    task test_done;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input [31:0] e, input [31:0] s);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task apb(input [7:0] a, input wr, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        exp_rd.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask
    task exs(input logic [7:0] q [$]);
        foreach (q[k]) exp_tx.push_back({k == q.size() - 1, q[k]});
    endtask
    task drain;
        for (int k = 0; k < 500 && exp_tx.size() > 0; k++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk("tx_pending", 32'h0, 32'(exp_tx.size()));
        rxq.delete();
    endtask
    task go(input [31:0] c);
        apb(8'h00, 1'b1, c | 32'h00550008);
        drain;
    endtask
    task pulse;
        @(posedge pclk);
        period_boundary <= 1'b1;
        @(posedge pclk);
        period_boundary <= 1'b0;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (presetn) ucyc <= ucyc + 1;
        if (psel && penable && !pwrite && exp_rd.size() > 0)
            chk("prdata", exp_rd.pop_front(), prdata);
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_tx.size() == 0) chk("tx_extra", 32'h0, 32'h1);
            else chk("tx_octet", {23'h0, exp_tx.pop_front()}, {23'h0, tx_last, tx_data});
        end
        if (cyc == 20000) begin
            errors++;
            test_done;
        end
    end
    initial begin
        void'($urandom(25249));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        apb(8'h28, 1'b1, $urandom);
        rd(8'h28, 32'h0);
        apb(8'h08, 1'b1, 32'h44332211);
        v = $urandom;
        apb(8'h04, 1'b1, v);
        rd(8'h04, {16'h0, v[15:0] & 16'h7F7E});
        exs({8'h11, 8'h04, v[7:0] & 8'h7E, v[15:8] & 8'h7F, 8'h00, 8'h00});
        go(32'h0);
        for (int k = 0; k < 8; k++) begin
            w = $urandom;
            apb(8'(8'h40 + 4 * k), 1'b1, w);
            for (int j = 0; j < 4; j++) rxq.push_back(w[8 * j +: 8]);
        end
        exs({8'h22, 8'h20, rxq});
        go(32'h00000201);
        w = $urandom;
        apb(8'h0C, 1'b1, {8'h00, w[15:0], 8'h01});
        exs({8'h33, 8'h03, 8'h01, w[7:0], w[15:8]});
        go(32'h2);
        pulse;
        rd(8'h24, 32'h0);
        pulse;
        rd(8'h24, {16'h0, w[15:0]});
        w = $urandom;
        apb(8'h10, 1'b1, w);
        rd(8'h10, w);
        apb(8'h00, 1'b1, 32'h0055000B);
        // local microsecond count: 50 clocks of 20 ns each since reset release
        v[15:0] = w[15:0] - 16'(ucyc / 50);
        exs({8'h44, 8'h04, v[7:0], v[15:8], w[23:16], w[31:24]});
        drain;
        for (int k = 0; k < 2; k++) begin
            v = $urandom;
            w = $urandom;
            eui[k] = {v[15:0], w} | 48'h1;
            @(posedge pclk);
            mcl_bind_valid <= 1'b1;
            mcl_bind_index <= 2'(k);
            mcl_ext_ident <= eui[k];
            @(posedge pclk);
            mcl_bind_valid <= 1'b0;
            for (int j = 0; j < 6; j++) rxq.push_back(eui[k][8 * j +: 8]);
            rxq.push_back(8'(k));
            rxq.push_back(8'hFF);
        end
        exs({8'h55, 8'h10, rxq});
        go(32'h00002004);
        grp_ext_ident <= eui[1];
        repeat (3) @(posedge pclk);
        chk("grp_hit", 32'h1, {31'h0, grp_hit_q});
        chk("grp_addr", 32'hFF01, {16'h0, grp_short_addr_q});
        grp_ext_ident <= ~eui[1];
        repeat (3) @(posedge pclk);
        chk("grp_miss", 32'h0, {31'h0, grp_hit_q});
        v = $urandom & 32'h7F7E;
        w = $urandom;
        rxq = {8'h11, 8'h02, v[7:0], v[15:8], 8'h77, 8'h04, 8'h11, 8'h02, 8'hFF, 8'hFF,
            8'h44, 8'h04, w[7:0], w[15:8], w[23:16], w[31:24],
            8'h33, 8'h03, w[31:24], w[7:0], w[15:8]};
        foreach (rxq[k]) peer_u.send(rxq[k]);
        peer_u.idle();
        repeat (3) @(posedge pclk);
        rd(8'h18, {16'h0, v[15:0]});
        rd(8'h20, w);
        rd(8'h1C, {8'h00, w[15:0], w[31:24]});
        test_done;
    end
endmodule
`default_nettype wire
